// ### hdl/pcs_cfg.svh
// Constants shared by both ends of the reference switchover link.
// Assumes pclk at 25 MHz; CYC counts are in pclk cycles, lock and hold counts in reference falls.
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// Mode codes carried on the mode lines
`define PCS_MODE_MANUAL 2'h0
`define PCS_MODE_AUTO   2'h1
`define PCS_MODE_OVR    2'h2

// Bandwidth codes and the lock edge count that each implies
`define PCS_BW_LOW      2'h0
`define PCS_BW_MED      2'h1
`define PCS_BW_HIGH     2'h2
`define PCS_LOCK_LOW    5'h10
`define PCS_LOCK_MED    5'h08
`define PCS_LOCK_HIGH   5'h04

// Request must be seen high on this many reference falling edges
`define PCS_SW_HOLD     2'h3
// Width of the per-reference edge interval counters
`define PCS_CNT_W       10

// Reset pulse after a switchover
`define PCS_CLK_NS      40
`define PCS_RST_MIN_NS  10
`define PCS_RST_CYC     ((`PCS_RST_MIN_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)

// Core end timing: request high and low minimum, lock stable time
`define PCS_HOLD_CYC    8'h40
`define PCS_LOW_CYC     8'h40
`define PCS_STABLE_CYC  8'h20

// Register offsets and control field positions
`define PCS_OFS_CTRL    12'h000
`define PCS_OFS_STATUS  12'h004
`define PCS_C_REQ       0
`define PCS_C_MODE      1
`define PCS_C_BW        3
`define PCS_C_APFD      5
`define PCS_C_OEN       6
`define PCS_C_RST       7
`define PCS_CTRL_RST    7'h68

`endif

// ### hdl/pcs_pkg.sv
// Types for the reference switchover ends.
// Assumes pcs_cfg.svh holds every number.
package pcs_pkg;

    // Switchover sequence
    typedef enum logic [1:0] {
        pcs_st_run,
        pcs_st_gate,
        pcs_st_new
    } pcs_state_t;

endpackage : pcs_pkg

// ### hdl/pcs_if.sv
// Link between the switchover device and the core logic that steers it.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps

interface pcs_if;
    logic       switch_req;
    logic       pll_reset;
    logic       pfd_enable;
    logic [1:0] mode;
    logic [1:0] bw_sel;
    logic       active_ref;
    logic [1:0] lost_ref;
    logic       locked;

    // Device end
    modport dev (
        input  switch_req,
        input  pll_reset,
        input  pfd_enable,
        input  mode,
        input  bw_sel,
        output active_ref,
        output lost_ref,
        output locked
    );

    // Core logic end
    modport core (
        output switch_req,
        output pll_reset,
        output pfd_enable,
        output mode,
        output bw_sel,
        input  active_ref,
        input  lost_ref,
        input  locked
    );
endinterface : pcs_if

// ### hdl/pcs_sense.sv
// Clock sense: edge events and stopped-clock flags for two references.
// Assumes references are sampled synchronously and run well below pclk/2.
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pcs_sense (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] ref_in,
    output logic [1:0]      fall,
    output logic [1:0]      lost
);
    localparam int W = `PCS_CNT_W;

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            logic         prev_reg;
            logic [W-1:0] idle_reg;
            logic [W-1:0] half_reg;
            logic         lost_reg;

            // One-cycle pulse in the cycle the reference is seen low
            assign fall[i] = prev_reg & ~ref_in[i];
            assign lost[i] = lost_reg;

            // Half period is the gap between any two edges
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    prev_reg <= 1'b0;
                    idle_reg <= '0;
                    half_reg <= '0;
                end else begin
                    prev_reg <= ref_in[i];
                    if (prev_reg != ref_in[i]) begin
                        idle_reg <= '0;
                        half_reg <= idle_reg;
                    end else if (idle_reg != {W{1'b1}}) begin
                        idle_reg <= idle_reg + 1'b1;
                    end
                end
            end

            // Static for four half periods, two cycles, is a loss [R19]
            // Clears on the next edge; no measurement, no flag
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lost_reg <= 1'b0;
                end else if (prev_reg != ref_in[i]) begin
                    lost_reg <= 1'b0;
                end else begin
                    lost_reg <= (half_reg != '0) &&
                        ({2'b00, idle_reg} >= {half_reg, 2'b00});
                end
            end
        end
    endgenerate

endmodule : pcs_sense

// ### hdl/pcs_switchover.sv
// Switchover device: picks one of two reference clocks for the PLL.
// Assumes pclk oversamples both references by at least 4x and that the
// core end drives the control side of pcs_if from the same pclk.
//
// Contract
// R01: Switch lands on falling edge of available clock
// R02: Override mode: request forces switch; >2x needs it
// R03: Gate output at next falling edge of current
// R04: At new clock fall switch mux, flag active
// R05: Request only while both references toggle; the core checks lost flags, raised only in auto and override
// R06: Manual switch: active follows request, no lost flags
// R07: Only request rising edge acts; repeats later
// R08: Wait until target reference is available
// R09: Primary reference selected after reset
// R10: Request held high three reference cycles
// R11: Request returns low before next switch
// R12: High time counts slower reference cycles
// R13: Loss flags valid only within 2x frequency
// R14: Pulse PLL reset after each switchover
// R15: Output clocks off until lock is stable
// R16: Lost flags may drop phase detector enable
// R17: Output enables suppress clocks during switchover
// R18: Three bandwidths, medium after reset
// R19: Static for two cycles raises lost flag
// R20: PLL reset clears counters, output, lock
// R21: Request sampled on selected reference edges
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pcs_switchover (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic ref_clock_primary,
    input  wire logic ref_clock_backup,
    pcs_if.dev        link,
    output logic      gated_ref,
    output logic [1:0] bw_active
);
    logic [1:0]          ref_now;
    logic [1:0]          fall;
    logic [1:0]          lost_raw;
    logic                sel_reg;
    logic                gate_off_reg;
    logic                armed_reg;
    logic [1:0]          hold_reg;
    logic [1:0]          lost_reg;
    logic [1:0]          bw_reg;
    logic [4:0]          lock_cnt_reg;
    logic [4:0]          lock_target;
    logic                locked_reg;
    logic                gated_ref_reg;
    logic                man_en;
    logic                auto_en;
    logic                cur_fall;
    logic                new_fall;
    logic                cur_lost;
    logic                man_trig;
    logic                auto_trig;
    logic                go_new;
    logic                done;
    pcs_pkg::pcs_state_t state_reg;

    assign ref_now = {ref_clock_backup, ref_clock_primary};

    // Edge events and loss flags for both references
    pcs_sense u_sense (
        .pclk    (pclk),
        .presetn (presetn),
        .ref_in  (ref_now),
        .fall    (fall),
        .lost    (lost_raw)
    );

    // Mode decode; an unknown code falls back to manual only
    assign man_en  = (link.mode != `PCS_MODE_AUTO);
    assign auto_en = (link.mode == `PCS_MODE_AUTO) ||
                     (link.mode == `PCS_MODE_OVR);

    // Events on the reference in use and on the one to switch to
    assign cur_fall = fall[sel_reg];
    assign new_fall = fall[!sel_reg];
    assign cur_lost = lost_raw[sel_reg];

    // Third high sample after a low one starts a manual switch
    assign man_trig = man_en && (state_reg == pcs_pkg::pcs_st_run) &&
                      armed_reg && cur_fall && link.switch_req &&
                      (hold_reg == `PCS_SW_HOLD - 2'h1); // [R07] [R10]

    // Loss of the current clock; manual wins in override [R02]
    assign auto_trig = auto_en && cur_lost && !man_trig &&
                       (state_reg == pcs_pkg::pcs_st_run);

    // Gate closes at current fall, or at once if current is dead in a sensing mode
    assign go_new = auto_trig ||
                    ((state_reg == pcs_pkg::pcs_st_gate) &&
                     (cur_fall || (auto_en && cur_lost))); // [R03]

    // Mux moves only on a fall of the target clock [R01] [R04]
    assign done = (state_reg == pcs_pkg::pcs_st_new) && new_fall;

    // Request is sampled only on falls of the selected reference;
    // a request that never drops low is never re-armed [R21] [R07]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_reg <= 1'b0;
            hold_reg  <= 2'h0;
        end else if (man_trig) begin
            armed_reg <= 1'b0;
            hold_reg  <= 2'h0;
        end else if (state_reg != pcs_pkg::pcs_st_run) begin
            hold_reg  <= 2'h0;
        end else if (cur_fall) begin
            if (!link.switch_req) begin
                armed_reg <= 1'b1;
                hold_reg  <= 2'h0;
            end else if (armed_reg) begin
                hold_reg  <= hold_reg + 2'h1; // [R10]
            end
        end
    end

    // Switchover sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= pcs_pkg::pcs_st_run;
        end else begin
            case (state_reg)
                pcs_pkg::pcs_st_run: begin
                    if (man_trig) begin
                        state_reg <= pcs_pkg::pcs_st_gate;
                    end else if (auto_trig) begin
                        state_reg <= pcs_pkg::pcs_st_new;
                    end
                end
                pcs_pkg::pcs_st_gate: begin
                    if (go_new) begin
                        state_reg <= pcs_pkg::pcs_st_new;
                    end
                end
                pcs_pkg::pcs_st_new: begin
                    // Stays here while the target is stopped [R08]
                    if (done) begin
                        state_reg <= pcs_pkg::pcs_st_run;
                    end
                end
                default: begin
                    state_reg <= pcs_pkg::pcs_st_run;
                end
            endcase
        end
    end

    // Gate is shut from the current fall, or a sensed loss, to the target fall [R03]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_off_reg <= 1'b0;
        end else if (done) begin
            gate_off_reg <= 1'b0;
        end else if (go_new) begin
            gate_off_reg <= 1'b1;
        end
    end

    // Selection; primary after reset [R09] [R04]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= 1'b0;
        end else if (done) begin
            sel_reg <= !sel_reg; // [R06]
        end
    end

    // Loss flags only in the sensing modes; outside 2x they are
    // unreliable and are reported as sensed, not corrected [R13] [R06]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lost_reg <= 2'h0;
        end else begin
            lost_reg <= auto_en ? lost_raw : 2'h0; // [R19]
        end
    end

    // Gated reference; low while gated or held in reset.
    // Registered, so it lags the selected input by one pclk.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_ref_reg <= 1'b0;
        end else begin
            gated_ref_reg <= ref_now[sel_reg] && !gate_off_reg &&
                             !go_new && !link.pll_reset; // [R03] [R20]
        end
    end

    // Bandwidth is taken only while the PLL is held in reset, so a
    // running loop never changes character; bad codes mean medium
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bw_reg <= `PCS_BW_MED; // [R18]
        end else if (link.pll_reset) begin
            if (link.bw_sel == `PCS_BW_LOW ||
                link.bw_sel == `PCS_BW_HIGH) begin
                bw_reg <= link.bw_sel;
            end else begin
                bw_reg <= `PCS_BW_MED;
            end
        end
    end

    // Narrow loops take longer to lock [R18]
    always_comb begin
        case (bw_reg)
            `PCS_BW_LOW:  lock_target = `PCS_LOCK_LOW;
            `PCS_BW_HIGH: lock_target = `PCS_LOCK_HIGH;
            default:      lock_target = `PCS_LOCK_MED;
        endcase
    end

    // Lock model: counts reference falls that pass the gate.
    // Frozen while the phase detector is off, since lock means
    // nothing without it; any gating or reset drops it [R20]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_cnt_reg <= 5'h00;
        end else if (link.pll_reset || gate_off_reg || go_new) begin
            lock_cnt_reg <= 5'h00;
        end else if (link.pfd_enable && cur_fall &&
                     lock_cnt_reg < lock_target) begin
            lock_cnt_reg <= lock_cnt_reg + 5'h01;
        end
    end

    // Lock indication, deasserted one pclk after PLL reset rises [R20]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            locked_reg <= 1'b0;
        end else begin
            locked_reg <= !link.pll_reset && !gate_off_reg && !go_new &&
                          (lock_cnt_reg >= lock_target);
        end
    end

    // Status toward the core end
    assign link.active_ref = sel_reg;
    assign link.lost_ref   = lost_reg;
    assign link.locked     = locked_reg;
    assign gated_ref       = gated_ref_reg;
    assign bw_active       = bw_reg;

endmodule : pcs_switchover

// ### hdl/pcs_core_ctrl.sv
// Core end: APB registers that steer the switchover device.
// Assumes an APB master on pclk and the device on the same pclk.
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pcs_core_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    pcs_if.core              link,
    output logic             out_clk_enable
);
    logic [6:0]  ctrl_reg;
    logic [31:0] prdata_reg;
    logic        err_reg;
    logic        req_reg;
    logic [7:0]  req_cnt_reg;
    logic        act_prev_reg;
    logic [3:0]  rst_cnt_reg;
    logic [7:0]  stable_cnt_reg;
    logic        pfd_reg;
    logic        oen_reg;
    logic        wr_ctrl;
    logic        kick;
    logic        any_lost;
    logic [31:0] status;

    // Zero wait states; read data was latched in the setup cycle
    assign pready  = psel && penable;
    assign pslverr = pready && err_reg;
    assign prdata  = prdata_reg;
    assign wr_ctrl = pready && pwrite && (paddr == `PCS_OFS_CTRL);
    assign kick    = wr_ctrl && pwdata[`PCS_C_RST];
    assign any_lost = |link.lost_ref;
    assign status  = {25'h0, oen_reg, (rst_cnt_reg != 4'h0), req_reg,
                      link.locked, link.lost_ref, link.active_ref};

    // Control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `PCS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= pwdata[6:0];
        end
    end

    // Read data and error decided in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            err_reg    <= 1'b0;
        end else if (psel && !penable) begin
            err_reg <= (paddr != `PCS_OFS_CTRL) &&
                       (paddr != `PCS_OFS_STATUS);
            if (paddr == `PCS_OFS_CTRL) begin
                prdata_reg <= {25'h0, ctrl_reg};
            end else if (paddr == `PCS_OFS_STATUS) begin
                prdata_reg <= status;
            end else begin
                prdata_reg <= 32'h0;
            end
        end
    end

    // Request rises only with no lost flag, which manual modes never raise [R05]; it stays
    // up a minimum [R10] [R12] and must fall before the next [R11]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg     <= 1'b0;
            req_cnt_reg <= 8'h00;
        end else if (!req_reg && ctrl_reg[`PCS_C_REQ] && !any_lost &&
                     req_cnt_reg >= `PCS_LOW_CYC) begin
            req_reg     <= 1'b1; // [R02]
            req_cnt_reg <= 8'h00;
        end else if (req_reg && !ctrl_reg[`PCS_C_REQ] &&
                     req_cnt_reg >= `PCS_HOLD_CYC) begin
            req_reg     <= 1'b0; // [R11]
            req_cnt_reg <= 8'h00;
        end else if (req_cnt_reg != 8'hFF) begin
            req_cnt_reg <= req_cnt_reg + 8'h01;
        end
    end

    // Reset pulse on every change of active reference, or on demand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_prev_reg <= 1'b0;
            rst_cnt_reg  <= 4'h0;
        end else begin
            act_prev_reg <= link.active_ref;
            if (kick || act_prev_reg != link.active_ref) begin
                rst_cnt_reg <= 4'(`PCS_RST_CYC); // [R14]
            end else if (rst_cnt_reg != 4'h0) begin
                rst_cnt_reg <= rst_cnt_reg - 4'h1;
            end
        end
    end

    // Phase detector held off while a loss is flagged [R16]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pfd_reg <= 1'b1;
        end else begin
            pfd_reg <= !(ctrl_reg[`PCS_C_APFD] && any_lost);
        end
    end

    // Outputs enabled only after lock has stood a while [R15] [R17]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_cnt_reg <= 8'h00;
            oen_reg        <= 1'b0;
        end else begin
            if (!link.locked || rst_cnt_reg != 4'h0) begin
                stable_cnt_reg <= 8'h00;
            end else if (stable_cnt_reg != `PCS_STABLE_CYC) begin
                stable_cnt_reg <= stable_cnt_reg + 8'h01;
            end
            oen_reg <= ctrl_reg[`PCS_C_OEN] && link.locked && !any_lost &&
                       (stable_cnt_reg == `PCS_STABLE_CYC);
        end
    end

    assign link.switch_req = req_reg;
    assign link.pll_reset  = (rst_cnt_reg != 4'h0);
    assign link.pfd_enable = pfd_reg;
    assign link.mode       = ctrl_reg[`PCS_C_MODE +: 2];
    assign link.bw_sel     = ctrl_reg[`PCS_C_BW +: 2];
    assign out_clk_enable  = oen_reg;

endmodule : pcs_core_ctrl

// ### test/pcs_link_sva.sv
// Checker for the link between the core end and the switchover device.
// Assumes instantiation beside the pcs_if instance, all on one pclk.
`timescale 1ns/1ps

module pcs_link_sva (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       switch_req,
    input wire logic       pll_reset,
    input wire logic       pfd_enable,
    input wire logic [1:0] mode,
    input wire logic [1:0] bw_sel,
    input wire logic       active_ref,
    input wire logic [1:0] lost_ref,
    input wire logic       locked
);
    // One clock domain, so defaults are declared once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Device end
    AST_PRIMARY_AFTER_RESET: assert property (
        $rose(presetn) |-> active_ref == 1'b0)
        else $error("active reference not primary after reset");
    AST_MANUAL_NO_LOSS: assert property (
        (mode == 2'h0) [*2] |-> lost_ref == 2'h0)
        else $error("lost flag raised in manual mode");
    AST_MANUAL_NEEDS_REQ: assert property (
        (mode == 2'h0 && $changed(active_ref)) |-> switch_req)
        else $error("manual switch without a request");
    AST_FALL_NO_RETURN: assert property (
        ($fell(switch_req) && mode == 2'h0) |=> $stable(active_ref) [*8])
        else $error("request fall changed the active reference");
    AST_RESET_DROPS_LOCK: assert property (
        pll_reset |=> !locked)
        else $error("lock held through PLL reset");
    AST_RELOCK_TAKES_TIME: assert property (
        $fell(pll_reset) |-> !locked [*8])
        else $error("lock came back too soon after reset");

    // Core end
    AST_RESET_AFTER_SWITCH: assert property (
        $changed(active_ref) |-> ##[1:2] pll_reset)
        else $error("no PLL reset pulse after a switch");
    AST_RESET_PULSE_WIDTH: assert property (
        $rose(pll_reset) |=> !pll_reset)
        else $error("PLL reset pulse longer than one cycle");
    AST_REQ_HELD_HIGH: assert property (
        $rose(switch_req) |=> switch_req [*8])
        else $error("switch request dropped too early");
    AST_PFD_OFF_ON_LOSS: assert property (
        (lost_ref != 2'h0) |-> ##[0:2] !pfd_enable)
        else $error("phase detector left on during loss");

    // Main scenarios reached
    COV_MANUAL: cover property (mode == 2'h0 && $changed(active_ref));
    COV_BOTH_LOST: cover property (lost_ref == 2'h3);
    COV_OVERRIDE: cover property (mode == 2'h2 && $changed(active_ref));
endmodule : pcs_link_sva

// ### test/testbench.sv
// Self-checking bench: core end and device end joined through pcs_if.
// Assumes pcs_cfg.svh offsets; references are made synchronous to pclk.
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module testbench;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, seed;
    logic        pready, pslverr, gated_ref, oen, e, sel_ref_q;
    logic [1:0]  bw_active, lost_seen;
    logic        ref_p, ref_b, run_p, run_b;
    int          hp_p = 4, hp_b = 5, cnt_p, cnt_b, cyc, fails, tests_run, i;

    pcs_if link ();
    pcs_switchover u_pcs_switchover (.pclk(pclk), .presetn(presetn),
        .ref_clock_primary(ref_p), .ref_clock_backup(ref_b),
        .link(link.dev), .gated_ref(gated_ref), .bw_active(bw_active));
    pcs_core_ctrl u_pcs_core_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.core), .out_clk_enable(oen));
    pcs_link_sva u_pcs_link_sva (.pclk(pclk), .presetn(presetn),
        .switch_req(link.switch_req), .pll_reset(link.pll_reset),
        .pfd_enable(link.pfd_enable), .mode(link.mode),
        .bw_sel(link.bw_sel), .active_ref(link.active_ref),
        .lost_ref(link.lost_ref), .locked(link.locked));

    // Clock at 40 ns
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // References toggle on pclk; a stopped one keeps its level
    always @(posedge pclk) begin
        cnt_p <= (cnt_p + 1) % hp_p;
        cnt_b <= (cnt_b + 1) % hp_b;
        if (run_p && cnt_p == hp_p - 1) ref_p <= ~ref_p;
        if (run_b && cnt_b == hp_b - 1) ref_b <= ~ref_b;
    end

    // Gated output may only carry the selected input, one pclk late
    always @(posedge pclk) begin
        sel_ref_q <= link.active_ref ? ref_b : ref_p;
        if (presetn === 1'b1 && gated_ref === 1'b1)
            chk("gated_ref", sel_ref_q, 1'b1);
    end

    // Hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Code 3 behaves as medium
    function automatic logic [1:0] exp_bw(input logic [1:0] c);
        return (c == 2'h3) ? 2'h1 : c;
    endfunction : exp_bw

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== ex) begin
            fails = fails + 1;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // One APB transfer; waits for pready, expected in the first access
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        repeat (rnd() % 3) @(posedge pclk);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // No limit here; the hang guard ends a transfer that never answers
        do begin
            @(posedge pclk);
            n = n + 1;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        chk("pready_wait", 32'h1, n);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Bounded wait for the active reference, noting any lost flag
    task automatic wait_active(input logic v);
        for (int n = 0; n < 800 && link.active_ref !== v; n++) begin
            @(posedge pclk);
            lost_seen = lost_seen | link.lost_ref;
        end
    endtask : wait_active

    task automatic give_verdict();
        if (fails == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ref_p, ref_b, run_p, run_b, cnt_p, cnt_b, cyc} = '0;
        {fails, tests_run} = '0;
        seed = 32'h00007994;
        hp_p = 4 + int'(rnd() % 3);
        hp_b = 4 + int'(rnd() % 3);
        run_p = 1'b1;
        run_b = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        apb(0, `PCS_OFS_CTRL, 32'h0);
        chk("ctrl_reset", 32'h68, q);
        chk("bw_reset", 2'h1, bw_active);
        apb(0, `PCS_OFS_STATUS, 32'h0);
        chk("active_reset", 1'b0, q[0]);
        apb(0, 12'h008, 32'h0);
        chk("bad_err", 1'b1, e);
        chk("bad_data", 32'h0, q);
        for (i = 0; i < 800 && oen !== 1'b1; i++) @(posedge pclk);
        chk("out_enable", 1'b1, oen);
        chk("locked", 1'b1, link.locked);
        // Manual switch there and back, request dropped in between;
        // the way back uses mode code 3, which must act as manual
        for (i = 0; i < 2; i++) begin
            lost_seen = 2'h0;
            apb(1, `PCS_OFS_CTRL, 32'h69 | (i * 6));
            wait_active(i == 0);
            chk("active_manual", i == 0, link.active_ref);
            chk("lost_manual", 2'h0, lost_seen);
            apb(1, `PCS_OFS_CTRL, 32'h68 | (i * 6));
            repeat (100) @(posedge pclk);
            chk("active_hold", i == 0, link.active_ref);
        end
        // Every bandwidth code, latched by a PLL reset pulse
        for (i = 0; i < 4; i++) begin
            apb(1, `PCS_OFS_CTRL, 32'hE0 | (i << 3));
            repeat (4) @(posedge pclk);
            chk("bw_active", exp_bw(i), bw_active);
        end
        // Automatic mode: primary stops, then both, then primary returns
        apb(1, `PCS_OFS_CTRL, 32'h6A);
        run_p <= 1'b0;
        for (i = 0; i < 200 && link.lost_ref[0] !== 1'b1; i++)
            @(posedge pclk);
        chk("lost_primary", 1'b1, link.lost_ref[0]);
        wait_active(1'b1);
        chk("active_auto", 1'b1, link.active_ref);
        run_b <= 1'b0;
        repeat (150) @(posedge pclk);
        chk("active_wait", 1'b1, link.active_ref);
        run_p <= 1'b1;
        wait_active(1'b0);
        chk("active_back", 1'b0, link.active_ref);
        run_b <= 1'b1;
        // Override mode: request forces a switch with both running
        repeat (50) @(posedge pclk);
        apb(1, `PCS_OFS_CTRL, 32'h6D);
        wait_active(1'b1);
        chk("active_override", 1'b1, link.active_ref);
        apb(1, `PCS_OFS_CTRL, 32'h6C);
        repeat (20) @(posedge pclk);
        give_verdict();
    end
endmodule : testbench
